// ===== verilog/ssr_defs.svh
// Constants of the serial readout block: widths, edge counts and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

`define SSR_RES_BITS     14
`define SSR_CNT_W        5
`define SSR_EDGE_FIRST   5'h01
`define SSR_EDGE_MSB     5'h03
`define SSR_EDGE_ACQ     5'h10
`define SSR_EDGE_LAST    5'h12
`define SSR_CNT_RST      5'h00
`define SSR_CODE_RST     14'h0000
`define SSR_MASK_MSB     14'h2000
`define SSR_DOUT_RST     1'h0

`endif

// ===== verilog/ssr_pkg.sv
// Types shared by the readout controller and the approximation core.
// Assumes ssr_defs.svh is on the include path.
`include "ssr_defs.svh"

package ssr_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ARMED,
    PH_CONV,
    PH_ACQ
  } ssr_phase_t;

  typedef logic [`SSR_RES_BITS-1:0] ssr_code_t;
  typedef logic [`SSR_CNT_W-1:0]    ssr_cnt_t;

endpackage

// ===== verilog/ssr_sar_if.sv
// Link between the frame controller and the approximation core.
// Assumes both ends share one clock.
`include "ssr_defs.svh"

interface ssr_sar_if;
  logic              sample_load;
  logic              trial_step;
  ssr_pkg::ssr_code_t sample_code;
  logic              decided_bit;

  modport ctrl (
    output sample_load,
    output trial_step,
    output sample_code,
    input  decided_bit
  );

  modport core (
    input  sample_load,
    input  trial_step,
    input  sample_code,
    output decided_bit
  );
endinterface

// ===== verilog/ssr_sar_core.sv
// Successive-approximation register: holds the sampled code and decides one bit per step.
// Assumes load and step pulses come from the frame controller on the same clock.
`include "ssr_defs.svh"

module ssr_sar_core (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Controller side.
  ssr_sar_if.core   sar
);

  typedef struct packed {
    ssr_pkg::ssr_code_t held;
    ssr_pkg::ssr_code_t result;
    ssr_pkg::ssr_code_t mask;
  } ssr_core_state_t;

  ssr_core_state_t    s;
  ssr_core_state_t    next_s;
  ssr_pkg::ssr_code_t trial;

  ////////////////////////////////////////////////////////////////////////////////
  // The comparison stands in for the analog comparator against the capacitor array.
  assign trial           = s.result | s.mask;
  assign sar.decided_bit = (s.mask != `SSR_CODE_RST) && (s.held >= trial);

  always_comb begin
    next_s = s;
    if (sar.sample_load) begin
      next_s.held   = sar.sample_code; // RULE_08
      next_s.result = `SSR_CODE_RST;
      next_s.mask   = `SSR_MASK_MSB;
    end else if (sar.trial_step && (s.mask != `SSR_CODE_RST)) begin
      if (sar.decided_bit) begin
        next_s.result = trial; // RULE_18
      end
      next_s.mask = s.mask >> 1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_sar_final_code: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    (s.mask == `SSR_CODE_RST && $past(s.mask) == 14'h0001) |-> (s.result == s.held))
    else $error("Finished code differs from the sampled value.");

endmodule

// ===== verilog/ssr_readout.sv
// Frame and sequencing logic of a 14-bit successive-approximation converter with serial readout.
// Assumes the host drives frame select and the shift clock asynchronously to clk, far slower than clk.
//
// Functional notes
// RULE_01: No internal conversion clock; the shift clock paces conversion and output.
// RULE_02: A full conversion frame spans 18 shift clock cycles from the host.
// RULE_03: Result bits leave most significant bit first.
// RULE_04: Bits shifted in a frame come from that same frame's conversion.
// RULE_05: Raising frame select at any point aborts the conversion.
// RULE_06: Select falling starts a frame; select rising ends it.
// RULE_07: Data output driven only while select is low, otherwise released.
// RULE_08: Input is sampled at the moment select goes low.
// RULE_09: Conversion lasts through the first 15 shift clock periods of a frame.
// RULE_10: Acquisition begins on the 16th falling shift clock edge.
// RULE_11: Acquisition holds for the three periods that follow that switch.
// RULE_12: Select falling with clock high: conversion starts at next falling clock edge.
// RULE_13: Select falling with clock low counts as the first falling edge.
// RULE_14: Select and clock falling together enter conversion at once.
// RULE_15: Host keeps select falling clear of rising clock edges.
// RULE_16: Two leading zeros on edges one and two, result on edges 3 to 16.
// RULE_17: Data changes on falling clock edges for capture on rising edges.
// RULE_18: Result is straight unsigned binary.
// RULE_19: Edge count restarts whenever select is deasserted.
`include "ssr_defs.svh"

module ssr_readout (
  // System clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Serial link from the host.
  input  wire logic               frame_select_n,
  input  wire logic               conversion_shift_clock,
  output logic                    serial_result_out,
  output logic                    serial_result_oe_n,
  // Front end: digitised stand-in for the sampled input, on clk.
  input  wire ssr_pkg::ssr_code_t analog_code,
  // Phase status.
  output logic                    conversion_phase,
  output logic                    acquisition_phase
);

  typedef struct packed {
    logic                sel_s1;
    logic                sel_s2;
    logic                sel_d;
    logic                sclk_s1;
    logic                sclk_s2;
    logic                sclk_d;
    ssr_pkg::ssr_phase_t phase;
    ssr_pkg::ssr_cnt_t   edge_cnt;
    logic                dout;
    logic                drive;
  } ssr_rd_state_t;

  ssr_rd_state_t s;
  ssr_rd_state_t next_s;
  logic          sel_fall;
  logic          sclk_fall;
  ssr_pkg::ssr_cnt_t cnt_inc;

  ssr_sar_if sar ();

  ssr_sar_core u_core (
    .clk   (clk),
    .rst_n (rst_n),
    .sar   (sar.core)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Armed counts as conversion: the sample is already held while the first edge is awaited.
  // The same decode feeds the status pin and the checks, so both agree by construction.
  function automatic logic in_conversion(ssr_pkg::ssr_phase_t ph);
    return (ph == ssr_pkg::PH_CONV) || (ph == ssr_pkg::PH_ARMED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Both link pins pass two flops; edges are found on the second stage only.
  assign sel_fall  = s.sel_d & ~s.sel_s2; // RULE_06
  assign sclk_fall = s.sclk_d & ~s.sclk_s2; // RULE_01
  assign cnt_inc   = s.edge_cnt + `SSR_EDGE_FIRST;
  assign sar.sample_code = analog_code;

  always_comb begin
    next_s         = s;
    next_s.sel_s1  = frame_select_n;
    next_s.sel_s2  = s.sel_s1;
    next_s.sel_d   = s.sel_s2;
    next_s.sclk_s1 = conversion_shift_clock;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_d  = s.sclk_s2;
    sar.sample_load = 1'b0;
    sar.trial_step  = 1'b0;
    if (s.sel_s2) begin
      // A raised select abandons whatever the frame was doing.
      next_s.phase    = ssr_pkg::PH_IDLE; // RULE_05
      next_s.edge_cnt = `SSR_CNT_RST; // RULE_19
      next_s.drive    = 1'b0; // RULE_07
      next_s.dout     = `SSR_DOUT_RST;
    end else if (sel_fall) begin
      sar.sample_load = 1'b1; // RULE_08
      next_s.drive    = 1'b1; // RULE_07
      next_s.dout     = `SSR_DOUT_RST;
      if (!s.sclk_s2) begin
        // Clock already low, or falling with select: that fall is edge one.
        next_s.edge_cnt = `SSR_EDGE_FIRST; // RULE_13 RULE_14
        next_s.phase    = ssr_pkg::PH_CONV;
      end else begin
        next_s.edge_cnt = `SSR_CNT_RST; // RULE_12
        next_s.phase    = ssr_pkg::PH_ARMED;
      end
    end else if (sclk_fall) begin
      case (s.phase)
        ssr_pkg::PH_ARMED: begin
          next_s.edge_cnt = `SSR_EDGE_FIRST; // RULE_12
          next_s.phase    = ssr_pkg::PH_CONV;
        end
        ssr_pkg::PH_CONV: begin
          next_s.edge_cnt = cnt_inc; // RULE_09
          if (cnt_inc >= `SSR_EDGE_MSB) begin
            // Each bit is decided on the edge that shifts it, so there is no latency.
            sar.trial_step = 1'b1; // RULE_04
            next_s.dout    = sar.decided_bit; // RULE_03 RULE_16 RULE_17
          end
          if (cnt_inc == `SSR_EDGE_ACQ) begin
            next_s.phase = ssr_pkg::PH_ACQ; // RULE_10
          end
        end
        ssr_pkg::PH_ACQ: begin
          // Counting stops at the end of a full frame; extra edges change nothing.
          if (s.edge_cnt != `SSR_EDGE_LAST) begin
            next_s.edge_cnt = cnt_inc; // RULE_02 RULE_11
          end
        end
        default: begin
          next_s.phase = ssr_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Select resets high so that leaving reset never looks like the start of a frame.
      s         <= '0;
      s.sel_s1  <= 1'b1;
      s.sel_s2  <= 1'b1;
      s.sel_d   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign serial_result_out  = s.dout;
  assign serial_result_oe_n = ~s.drive;
  assign conversion_phase   = in_conversion(s.phase);
  assign acquisition_phase  = ~conversion_phase;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the internal sequence.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_oe_follows_select: assert property (s.sel_s2 |=> serial_result_oe_n) // RULE_07
    else $error("Output driven while select is high.");
  chk_select_drives_out: assert property (sel_fall |=> !serial_result_oe_n) // RULE_06
    else $error("Output not enabled after select fell.");
  chk_leading_zeros: assert property ((s.phase == ssr_pkg::PH_CONV && s.edge_cnt < `SSR_EDGE_MSB)
    |-> !serial_result_out) // RULE_16
    else $error("Leading bit is not zero.");
  chk_conv_until_16: assert property ((!s.sel_s2 && s.phase != ssr_pkg::PH_IDLE
    && s.edge_cnt < `SSR_EDGE_ACQ) |-> conversion_phase) // RULE_09
    else $error("Left conversion before edge sixteen.");
  chk_acq_at_16: assert property (($past(s.edge_cnt) == 5'h0f && s.edge_cnt == `SSR_EDGE_ACQ)
    |-> acquisition_phase) // RULE_10
    else $error("Acquisition not entered on edge sixteen.");
  chk_acq_holds: assert property ((s.phase == ssr_pkg::PH_ACQ && !s.sel_s2)
    |=> (s.phase == ssr_pkg::PH_ACQ) || s.sel_s2 || sel_fall) // RULE_11
    else $error("Acquisition left without a new frame.");
  chk_count_restart: assert property ($rose(s.sel_s2) |=> s.edge_cnt == `SSR_CNT_RST
    && s.phase == ssr_pkg::PH_IDLE) // RULE_19
    else $error("Edge count not cleared at frame end.");
  chk_low_clk_start: assert property ((sel_fall && !s.sclk_s2) |=> s.edge_cnt == `SSR_EDGE_FIRST
    && conversion_phase) // RULE_13
    else $error("Select fall with low clock not counted as edge one.");
  chk_high_clk_start: assert property ((sel_fall && s.sclk_s2) |=> s.phase == ssr_pkg::PH_ARMED
    ##0 s.edge_cnt == `SSR_CNT_RST) // RULE_12
    else $error("Select fall with high clock counted an edge.");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the held sample and the result bits, then on when the step, output and edge count may move.
  chk_sample_at_fall: assert property (sel_fall |=> u_core.s.held == $past(analog_code)) // RULE_08
    else $error("Held sample differs from the input at select fall.");
  chk_msb_first: assert property ((s.phase == ssr_pkg::PH_CONV && s.edge_cnt == `SSR_EDGE_MSB)
    |-> serial_result_out == u_core.s.held[`SSR_RES_BITS-1]) // RULE_03
    else $error("First result bit is not the most significant.");
  chk_lsb_held_acq: assert property ((s.phase == ssr_pkg::PH_ACQ)
    |-> serial_result_out == u_core.s.held[0]) // RULE_16
    else $error("Last result bit not held in acquisition.");
  chk_idle_out_low: assert property ((s.phase == ssr_pkg::PH_IDLE)
    |-> !serial_result_out) // RULE_19
    else $error("Output not back to a leading zero between frames.");
  chk_armed_no_step: assert property ((s.phase == ssr_pkg::PH_ARMED)
    |-> !sar.trial_step && !serial_result_out) // RULE_12
    else $error("Armed frame stepped or showed a bit before edge one.");
  chk_step_on_fall: assert property (sar.trial_step
    |-> (sclk_fall && in_conversion(s.phase))) // RULE_04
    else $error("Approximation stepped outside a conversion clock edge.");
  // Between detected events the output and the count must not move; a glitch here would shift a bit.
  chk_dout_on_falls: assert property ((!s.sel_s2 && !sel_fall && !sclk_fall)
    |=> $stable(serial_result_out)) // RULE_17
    else $error("Data changed without a falling clock edge.");
  chk_count_on_falls: assert property ((!s.sel_s2 && !sel_fall && !sclk_fall)
    |=> $stable(s.edge_cnt)) // RULE_01
    else $error("Edge count moved without a falling clock edge.");
  chk_count_ceiling: assert property (s.edge_cnt <= `SSR_EDGE_LAST) // RULE_02
    else $error("Edge count passed the end of a full frame.");

  // Main scenarios: full frame, short cycle, each start condition and the switch to acquisition.
  cov_full_frame: cover property (s.edge_cnt == `SSR_EDGE_LAST);
  cov_low_clk_start: cover property (sel_fall && !s.sclk_s2);
  cov_acq_entry: cover property (s.phase == ssr_pkg::PH_CONV ##1 s.phase == ssr_pkg::PH_ACQ);
  cov_short_cycle: cover property (s.phase == ssr_pkg::PH_CONV ##1 s.phase == ssr_pkg::PH_IDLE);
  cov_armed_start: cover property (s.phase == ssr_pkg::PH_ARMED ##1 s.phase == ssr_pkg::PH_CONV);

endmodule

// ===== tb/ssr_host_model.sv
// Host serial controller model: frames the link with select and a shift clock at 800 ns.
// Assumes clk runs at 100 ns; it drives only on falling clk edges.
module ssr_host_model (
  // Bench clock.
  input  wire logic clk,
  // Serial link.
  output logic      frame_select_n,
  output logic      conversion_shift_clock,
  input  wire logic sdata,
  // Falling shift clock edges so far in this frame.
  output int        n_fall
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    frame_select_n = 1'b1;
    conversion_shift_clock = 1'b1;
    n_fall = 0;
  end

  // Mode 0: select falls with clock high; 1: clock low; 2: both fall together.
  // Bits are taken late in the high phase, since the device answers several clk after each fall.
  task automatic frame(input int nf, input int mode, output logic [15:0] got);
    got = 16'h0000;
    conversion_shift_clock = (mode == 1) ? 1'b0 : 1'b1;
    repeat (4) @(negedge clk);
    frame_select_n = 1'b0;
    if (mode == 2) conversion_shift_clock = 1'b0;
    n_fall = (mode != 0) ? 1 : 0;
    // Four clk periods low and four high, so the shift clock keeps its 800 ns period across bits.
    for (int k = 1; k <= nf; k++) begin
      if (k > 1 || mode == 0) begin
        repeat ((k > 1) ? 1 : 4) @(negedge clk);
        conversion_shift_clock = 1'b0;
        n_fall = k;
      end
      repeat (4) @(negedge clk);
      conversion_shift_clock = 1'b1;
      repeat (3) @(negedge clk);
      if (k <= 16) got = {got[14:0], sdata};
    end
    @(negedge clk);
    frame_select_n = 1'b1;
    n_fall = 0;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ===== tb/ssr_readout_tb.sv
// Self-checking bench of the serial readout block, with the host model on the link.
// Assumes the design package is compiled first; inputs change on falling clk edges.
module ssr_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    ssr_pkg::ssr_code_t code;
    int                 nf;
    int                 mode;
  } ssr_row_t;

  logic               clk;
  logic               rst_n;
  ssr_pkg::ssr_code_t analog_code;
  logic               sel_n, sclk, dout, oe_n, conv, acq, sdata, last;
  int                 hf;
  int                 errors = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  logic [15:0]        got;
  ssr_row_t           rows[6] = '{'{14'h3fff, 18, 0}, '{14'h0000, 18, 1}, '{14'h2aaa, 16, 2},
                                  '{14'h1555, 18, 0}, '{14'h0001, 18, 1}, '{14'h2000, 17, 2}};

  ssr_readout DUT (.clk(clk), .rst_n(rst_n), .frame_select_n(sel_n), .conversion_shift_clock(sclk),
    .serial_result_out(dout), .serial_result_oe_n(oe_n), .analog_code(analog_code),
    .conversion_phase(conv), .acquisition_phase(acq));
  ssr_host_model host (.clk(clk), .frame_select_n(sel_n), .conversion_shift_clock(sclk),
    .sdata(sdata), .n_fall(hf));

  // A released line has no pull, so the host sees the inverse of the last driven bit rather than a stale copy of it.
  always @(posedge clk) if (!oe_n) last <= dout;
  assign sdata = oe_n ? ~last : dout;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Phase and enable seen at each rising shift clock inside a frame.
  always @(posedge sclk) if (sel_n === 1'b0) begin
    check({15'h0000, oe_n}, 16'h0000);
    if (hf <= 15) check({15'h0000, conv}, 16'h0001);
    else check({15'h0000, acq}, 16'h0001);
  end

  // The input code moves mid-frame, so only the value held at select fall may come out.
  task automatic run(input ssr_pkg::ssr_code_t c, input int nf, input int mode);
    analog_code = c;
    fork
      host.frame(nf, mode, got);
      begin
        repeat (12) @(negedge clk);
        analog_code = ~c;
      end
    join
    check(got, {2'b00, c} >> (16 - (nf > 16 ? 16 : nf)));
    check({14'h0000, oe_n, acq}, 16'h0003);
  endtask

  initial begin
    rst_n = 1'b0;
    analog_code = 14'h0000;
    repeat (6) @(negedge clk);
    check({12'h000, dout, oe_n, conv, acq}, 16'h0005);
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i].code, rows[i].nf, rows[i].mode);
    run(14'h2001, 5, 1);
    run(14'h3fff, 3, 2);
    run(14'h1234, 18, 0);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    check({12'h000, dout, oe_n, conv, acq}, 16'h0005);
    rst_n = 1'b1;
    run(14'h2bcd, 18, 1);
    conclude();
  end
endmodule
